//--- test/i2c_ctl_port_bench.sv
// Self-checking bench of the control port with a bus master model and a register map.
`timescale 1ns/1ps
module i2c_ctl_port_bench;
    localparam int TOP = 15;
    logic                  clk;
    logic                  lclk;
    logic                  arst_n;
    logic                  scl;
    logic                  sda_m;
    logic                  sda_out;
    logic                  sda_oe;
    logic [2:0]            addr_lvl;
    i2c_ctl_pkg::reg_req_t reg_req;
    logic [7:0]            reg_rdata;
    logic [7:0]            mem [256];
    logic [7:0]            exp_mem [256];
    logic [31:0]           seed = 32'h0000004d;
    int                    fail_count = 0;
    int                    compares = 0;
    int                    wr_seen = 0;
    int                    cycles = 0;
    // ------------------------------------------------------------
    // Wires, clocks and parties
    // ------------------------------------------------------------
    // The open-drain wire is low when either party pulls it, else the pull-up wins.
    wire sda_w = sda_m & (~sda_oe | sda_out);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Link clock starts off phase so the two domains never line up.
    initial begin
        lclk = 1'b0;
        #3.7;
        forever #6 lclk = ~lclk;
    end
    i2c_ctl_port #(.SUB_MAX(TOP)) DUT (
        .clk(clk), .arst_n(arst_n), .lclk(lclk), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_lvl(addr_lvl), .reg_req(reg_req), .reg_rdata(reg_rdata)
    );
    i2c_master_model M (.scl(scl), .sda_m(sda_m), .sda(sda_w));
    // Register map: read data is ready in the same cycle as the read pulse.
    always @(posedge clk) begin
        #1;
        if (reg_req.wr === 1'b1) begin
            mem[reg_req.addr] = reg_req.wdata;
            wr_seen++;
        end
        reg_rdata = mem[reg_req.addr];
    end
    // open drain only
    // Looked at on the falling edge, so the value is settled and never raced against its launch.
    always @(negedge lclk) if (sda_oe === 1'b1) check("sda_out", 8'h00, {7'h00, sda_out});
    // A hang counts as a mismatch and still ends in the report.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // The strap is caught only after reset, so each pin level needs its own reset.
    task automatic do_reset(input logic [2:0] lvl);
        @(posedge clk) #1 arst_n = 1'b0;
        addr_lvl = lvl;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] b, input logic ak, input string nm);
        logic [7:0] q;
        logic       a;
        M.xfer(b, 1'b1, q, a);
        check(nm, {7'h00, ak}, {7'h00, a});
    endtask
    task automatic open_w(input logic [7:0] s, input logic ak);
        M.start();
        send(8'h28, 1'b1, "address");
        send(s, ak, "subaddress");
    endtask
    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic [7:0] s;
        logic [7:0] d;
        logic       a;
        arst_n = 1'b0;
        addr_lvl = 3'h0;
        reg_rdata = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(xs());
            exp_mem[i] = mem[i];
        end
        for (int k = 0; k < 4; k++) begin
            do_reset(3'h7 >> (3 - k));
            M.start();
            send({7'h14 + 7'(k), 1'b0}, 1'b1, "own address");
            M.stop();
            M.start();
            send({7'h14 + 7'(k + 1), 1'b0}, 1'b0, "foreign address");
            M.stop();
        end
        $display("test straps done");
        do_reset(3'h0);
        wr_seen = 0;
        open_w(8'(TOP - 2), 1'b1);
        for (int i = 0; i < 4; i++) begin
            d = 8'(xs());
            send(d, i < 3, "burst ack");
            if (i < 3) exp_mem[TOP - 2 + i] = d;
        end
        M.stop();
        check("write count", 8'h03, 8'(wr_seen));
        for (int i = TOP - 2; i <= TOP + 1; i++) check("register", exp_mem[i], mem[i]);
        $display("test burst write done");
        open_w(8'(TOP + 1), 1'b0);
        send(8'h5a, 1'b0, "after refusal");
        M.stop();
        $display("test bad subaddress done");
        open_w(8'(TOP - 1), 1'b1);
        M.start();
        send(8'h29, 1'b1, "read address");
        for (int i = 0; i < 3; i++) begin
            M.xfer(8'hff, i == 2, q, a);
            check("read data", exp_mem[i == 0 ? TOP - 1 : TOP], q);
        end
        M.stop();
        $display("test burst read done");
        M.start();
        send(8'h28, 1'b1, "address");
        repeat (3) M.clk_bit(1'b1, a);
        M.start();
        send(8'h28, 1'b1, "restart address");
        repeat (3) M.clk_bit(1'b0, a);
        M.stop();
        send(8'ha8, 1'b0, "no start");
        $display("test abort done");
        for (int n = 0; n < 4; n++) begin
            s = 8'(xs() % (TOP + 1));
            d = 8'(xs());
            open_w(s, 1'b1);
            send(d, 1'b1, "data ack");
            exp_mem[s] = d;
            M.stop();
            open_w(s, 1'b1);
            M.start();
            send(8'h29, 1'b1, "read address");
            M.xfer(8'hff, 1'b1, q, a);
            check("readback", exp_mem[s], q);
            M.stop();
        end
        $display("test random done");
        stop_test();
    end
endmodule // i2c_ctl_port_bench

//--- test/i2c_master_model.sv
// Behavioural two-wire bus master that clocks every transfer of the control port.
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int Q = 200
) (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    // Both lines rest released; the pull-up holds them high between frames.
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // start and repeat
    // SDA is raised while SCL is low, so the same task makes a repeated start.
    task automatic start();
        sda_m = 1'b1;
        #Q scl = 1'b1;
        #Q sda_m = 1'b0;
        #Q scl = 1'b0;
        // Hold the data line past the falling clock before the first bit moves it.
        #Q;
    endtask

    task automatic stop();
        sda_m = 1'b0;
        #Q scl = 1'b1;
        #Q sda_m = 1'b1;
        #Q;
    endtask

    // one event per high
    // Data moves only while SCL is low, so no stray start or stop appears.
    task automatic clk_bit(input logic b, output logic r);
        sda_m = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask

    // byte and ninth clock
    // A low m_ack acknowledges a byte read from the device; high leaves it unacknowledged.
    task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic s_ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
            q[i] = r;
        end
        clk_bit(m_ack, r);
        s_ack = ~r;
    endtask
endmodule // i2c_master_model

//--- verilog/i2c_ctl_defs.svh
// Constants of the two-wire control port.
`ifndef I2C_CTL_DEFS_SVH
`define I2C_CTL_DEFS_SVH

// Fixed upper five bits of the 7-bit target address.
`define TGT_ADDR_HI 5'h05
// Default highest valid subaddress.
`define SUB_MAX_DEF 8'h0f
// Bits in one byte on the wire.
`define BYTE_BITS 4'h8
// Index of the last transmitted bit of a byte.
`define LAST_BIT 4'h7
// Link cycles waited after reset before the strap level is caught.
`define STRAP_WAIT 2'h3

`endif

//--- verilog/i2c_ctl_pkg.sv
// Shared types of the two-wire control port.
package i2c_ctl_pkg;

    // Byte phase of the link engine, Gray coded along idle, receive, ack, send, master ack.
    typedef enum logic [2:0] {
        P_IDLE = 3'h0,
        P_RECV = 3'h1,
        P_ACK  = 3'h3,
        P_SEND = 3'h2,
        P_MACK = 3'h6
    } phase_t;

    // Meaning of the byte being received.
    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_SUB  = 2'h1,
        K_DATA = 2'h3
    } kind_t;

    // Register access toward the device's register map.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        phase_t     phase;
        kind_t      kind;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic       rw;
        logic [8:0] ptr;
        logic       mack_ok;
        logic       oe;
        logic       sda_o;
        logic       scl_q;
        logic       sda_q;
        logic [1:0] cap_cnt;
        logic [1:0] strap;
        logic       req_tgl;
        logic       req_wr;
        logic [7:0] req_addr;
        logic [7:0] req_data;
        logic       ack_q;
        logic [7:0] rbyte;
    } link_state_t;

    typedef struct packed {
        logic       req_q;
        reg_req_t   req;
        logic [7:0] rdata;
        logic       ack_tgl;
    } core_state_t;

endpackage

//--- verilog/i2c_ctl_port.sv
// Two-wire target control port: link engine on the link clock, register access on the core clock.
//
// Contract
// R1 - Device is target only; it never starts or clocks a transfer.
// R2 - First byte is 7-bit address then direction bit, 1 read, 0 write.
// R3 - Five address bits fixed; two come from the address-select pin strap.
// R4 - Pin levels decode: pull-down 00, open 01, pull-up 10, supply 11.
// R5 - Strap settings map consecutively to target addresses 0x14 up to 0x17.
// R6 - Start is SDA falling while SCL is high.
// R7 - After start, shift eight bits in, most significant first.
// R8 - On match pull SDA low in ninth clock; on mismatch release, idle.
// R9 - Transfer ends at stop: SDA rising while SCL is high.
// R10 - Start or stop at any point sends the engine straight to idle; here a start goes straight to address receive instead.
// R11 - Master gives at most one start, stop, or stop-start per SCL high.
// R12 - Write: address, subaddress, data; device acknowledges every ninth clock.
// R13 - Invalid subaddress gets no acknowledge and the engine goes idle.
// R14 - Subaddress pointer advances by one after every data byte.
// R15 - Read: write subaddress, repeated start, address with direction 1.
// R16 - Master acknowledges each read byte and leaves the last unacknowledged.
// R17 - Read past the top keeps returning the highest register until no acknowledge.
// R18 - Write past the top is dropped, not acknowledged, engine goes idle.
// R19 - SDA is only ever pulled low or released, never driven high.
`timescale 1ns/1ps
`include "i2c_ctl_defs.svh"
module i2c_ctl_port #(
    parameter int SUB_MAX = int'(`SUB_MAX_DEF)
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  lclk,
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire logic [2:0]            addr_lvl,
    output i2c_ctl_pkg::reg_req_t      reg_req,
    input  wire logic [7:0]            reg_rdata
);
    localparam logic [8:0] TOP = 9'(SUB_MAX);

    if (SUB_MAX < 0 || SUB_MAX > 255) begin : g_bad_top
        $error("i2c_ctl_port needs SUB_MAX within one byte.");
    end

    i2c_ctl_pkg::link_state_t link;
    i2c_ctl_pkg::link_state_t next_link;
    i2c_ctl_pkg::core_state_t core;
    i2c_ctl_pkg::core_state_t next_core;

    logic [5:0] link_in;
    logic       scl_s;
    logic       sda_s;
    logic       ack_s;
    logic [1:0] strap_now;
    logic       req_s;
    logic       start_c;
    logic       stop_c;
    logic       rise_c;
    logic       fall_c;
    logic       my_addr;

    // Read pointer that never passes the top, so an overrun read repeats the highest register.
    function automatic logic [7:0] clamp(input logic [8:0] p);
        clamp = (p > TOP) ? TOP[7:0] : p[7:0];
    endfunction

    // ------------------------------------------------------------------
    // Crossings into each domain
    // ------------------------------------------------------------------

    // Pins and the answer toggle enter the link domain through two flops.
    sync_2ff #(
        .WIDTH (6)
    ) u_link_sync (
        .clk    (lclk),
        .arst_n (arst_n),
        .d      ({scl, sda_in, addr_lvl, core.ack_tgl}),
        .q      (link_in)
    );

    // The request toggle enters the core domain through two flops.
    sync_2ff #(
        .WIDTH (1)
    ) u_core_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (link.req_tgl),
        .q      (req_s)
    );

    // R4 four-level decode
    strap_decode u_strap (
        .lvl   (link_in[3:1]),
        .strap (strap_now)
    );

    assign scl_s = link_in[5];
    assign sda_s = link_in[4];
    assign ack_s = link_in[0];

    // ------------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------------

    // R6 start detect
    assign start_c = link.scl_q & scl_s & link.sda_q & ~sda_s;
    // R9 stop detect
    assign stop_c  = link.scl_q & scl_s & ~link.sda_q & sda_s;
    assign rise_c  = ~link.scl_q & scl_s;
    assign fall_c  = link.scl_q & ~scl_s;
    // R3 strap address match
    assign my_addr = (link.shreg[7:1] == {`TGT_ADDR_HI, link.strap});

    // ------------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------------

    // Phase steps are taken on sampled SCL edges; starts and stops, SDA edges while SCL is high, override any phase.
    always_comb begin
        next_link       = link;
        next_link.scl_q = scl_s;
        next_link.sda_q = sda_s;
        next_link.ack_q = ack_s;
        // R5 strap capture
        if (link.cap_cnt != `STRAP_WAIT) begin
            next_link.cap_cnt = link.cap_cnt + 2'h1;
            next_link.strap   = strap_now;
        end
        // The core holds its read byte stable from the toggle onward.
        if (ack_s != link.ack_q) begin
            next_link.rbyte = core.rdata;
        end
        // R10 start restarts
        if (start_c) begin
            next_link.phase   = i2c_ctl_pkg::P_RECV;
            next_link.kind    = i2c_ctl_pkg::K_ADDR;
            next_link.bitcnt  = 4'h0;
            next_link.oe      = 1'b0;
            next_link.mack_ok = 1'b0;
        // R9 stop idles
        end else if (stop_c) begin
            next_link.phase = i2c_ctl_pkg::P_IDLE;
            next_link.oe    = 1'b0;
        end else begin
            case (link.phase)
                i2c_ctl_pkg::P_RECV: begin
                    // R7 shift MSB first
                    if (rise_c) begin
                        next_link.shreg  = {link.shreg[6:0], sda_s};
                        next_link.bitcnt = link.bitcnt + 4'h1;
                    end else if (fall_c && link.bitcnt == `BYTE_BITS) begin
                        next_link.bitcnt = 4'h0;
                        next_link.phase  = i2c_ctl_pkg::P_IDLE;
                        case (link.kind)
                            i2c_ctl_pkg::K_ADDR: begin
                                // R8 match acknowledge
                                if (my_addr) begin
                                    next_link.phase = i2c_ctl_pkg::P_ACK;
                                    next_link.oe    = 1'b1;
                                    // R2 direction bit
                                    next_link.rw    = link.shreg[0];
                                    if (link.shreg[0]) begin
                                        next_link.req_tgl  = ~link.req_tgl;
                                        next_link.req_wr   = 1'b0;
                                        next_link.req_addr = clamp(link.ptr);
                                    end
                                end
                            end
                            i2c_ctl_pkg::K_SUB: begin
                                // R13 subaddress check
                                if ({1'b0, link.shreg} <= TOP) begin
                                    next_link.ptr   = {1'b0, link.shreg};
                                    next_link.phase = i2c_ctl_pkg::P_ACK;
                                    next_link.oe    = 1'b1;
                                end
                            end
                            default: begin
                                // R18 overrun drop
                                if (link.ptr <= TOP) begin
                                    next_link.req_tgl  = ~link.req_tgl;
                                    next_link.req_wr   = 1'b1;
                                    next_link.req_addr = link.ptr[7:0];
                                    next_link.req_data = link.shreg;
                                    // R14 pointer advance
                                    next_link.ptr      = link.ptr + 9'h001;
                                    // R12 data acknowledge
                                    next_link.phase    = i2c_ctl_pkg::P_ACK;
                                    next_link.oe       = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                i2c_ctl_pkg::P_ACK: begin
                    // The ninth clock ends at its falling edge; the bus turns round there.
                    if (fall_c) begin
                        next_link.bitcnt = 4'h0;
                        if (link.rw) begin
                            next_link.phase = i2c_ctl_pkg::P_SEND;
                            next_link.shreg = next_link.rbyte;
                            // R19 pull low only
                            next_link.oe    = ~next_link.rbyte[7];
                        end else begin
                            next_link.phase = i2c_ctl_pkg::P_RECV;
                            next_link.oe    = 1'b0;
                            next_link.kind  = (link.kind == i2c_ctl_pkg::K_ADDR) ? i2c_ctl_pkg::K_SUB
                                                                                  : i2c_ctl_pkg::K_DATA;
                        end
                    end
                end
                i2c_ctl_pkg::P_SEND: begin
                    if (fall_c) begin
                        if (link.bitcnt == `LAST_BIT) begin
                            next_link.phase   = i2c_ctl_pkg::P_MACK;
                            next_link.oe      = 1'b0;
                            next_link.mack_ok = 1'b0;
                        end else begin
                            next_link.bitcnt = link.bitcnt + 4'h1;
                            next_link.shreg  = {link.shreg[6:0], 1'b0};
                            next_link.oe     = ~link.shreg[6];
                        end
                    end
                end
                i2c_ctl_pkg::P_MACK: begin
                    // R16 master answer
                    if (rise_c) begin
                        if (sda_s) begin
                            next_link.phase = i2c_ctl_pkg::P_IDLE;
                        end else begin
                            next_link.mack_ok = 1'b1;
                            // R17 hold at top
                            if (link.ptr < TOP) begin
                                next_link.ptr = link.ptr + 9'h001;
                            end
                            next_link.req_tgl  = ~link.req_tgl;
                            next_link.req_wr   = 1'b0;
                            next_link.req_addr = clamp(next_link.ptr);
                        end
                    end else if (fall_c && link.mack_ok) begin
                        next_link.phase   = i2c_ctl_pkg::P_SEND;
                        next_link.bitcnt  = 4'h0;
                        next_link.mack_ok = 1'b0;
                        next_link.shreg   = next_link.rbyte;
                        next_link.oe      = ~next_link.rbyte[7];
                    end
                end
                default: begin
                    next_link.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge lclk or negedge arst_n) begin
        if (!arst_n) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // ------------------------------------------------------------------
    // Core-side register access
    // ------------------------------------------------------------------

    // Request fields launch with their toggle and then hold, so they are safe to sample once it lands through two flops.
    always_comb begin
        next_core        = core;
        next_core.req.wr = 1'b0;
        next_core.req.rd = 1'b0;
        if (core.req.rd) begin
            next_core.rdata   = reg_rdata;
            next_core.ack_tgl = ~core.ack_tgl;
        end
        if (req_s != core.req_q) begin
            next_core.req_q     = req_s;
            next_core.req.addr  = link.req_addr;
            next_core.req.wdata = link.req_data;
            next_core.req.wr    = link.req_wr;
            next_core.req.rd    = ~link.req_wr;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    // R1 target-only drive
    assign sda_oe  = link.oe;
    assign sda_out = link.sda_o;
    assign reg_req = core.req;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    sequence s_ack_driven;
        link.phase == i2c_ctl_pkg::P_ACK && link.oe;
    endsequence

    sequence s_released;
        link.phase == i2c_ctl_pkg::P_IDLE && !link.oe;
    endsequence

    AST_START_RECV: // R6
    assert property (@(posedge lclk) disable iff (!arst_n)
        start_c |=> link.phase == i2c_ctl_pkg::P_RECV && link.bitcnt == 4'h0 && !link.oe)
        else $error("Start did not restart address reception.");

    AST_STOP_IDLE: // R9
    assert property (@(posedge lclk) disable iff (!arst_n) stop_c |=> s_released)
        else $error("Stop did not release the bus.");

    AST_SHIFT_IN: // R7
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_RECV && rise_c |=> link.shreg[0] == $past(sda_s))
        else $error("Received bit not shifted in at the low end.");

    AST_ADDR_ACK: // R8
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_RECV && link.kind == i2c_ctl_pkg::K_ADDR && fall_c
        && link.bitcnt == `BYTE_BITS && my_addr |=> s_ack_driven ##1 link.oe)
        else $error("Matching address not acknowledged.");

    AST_ADDR_MISS: // R3
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_RECV && link.kind == i2c_ctl_pkg::K_ADDR && fall_c
        && link.bitcnt == `BYTE_BITS && !my_addr |=> s_released)
        else $error("Foreign address not ignored.");

    AST_SUB_BAD: // R13
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_RECV && link.kind == i2c_ctl_pkg::K_SUB && fall_c
        && link.bitcnt == `BYTE_BITS && {1'b0, link.shreg} > TOP |=> s_released)
        else $error("Invalid subaddress was acknowledged.");

    AST_WR_OVERRUN: // R18
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_RECV && link.kind == i2c_ctl_pkg::K_DATA && fall_c
        && link.bitcnt == `BYTE_BITS && link.ptr > TOP |=> s_released and $stable(link.req_tgl))
        else $error("Overrun write byte was not dropped.");

    AST_PTR_INC: // R14
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_RECV && link.kind == i2c_ctl_pkg::K_DATA && fall_c
        && link.bitcnt == `BYTE_BITS && link.ptr <= TOP |=> link.ptr == $past(link.ptr) + 9'h001)
        else $error("Pointer did not advance after a data byte.");

    AST_RD_CLAMP: // R17
    assert property (@(posedge lclk) disable iff (!arst_n)
        !link.req_wr && $changed(link.req_tgl) |-> {1'b0, link.req_addr} <= TOP)
        else $error("Read request beyond the highest register.");

    AST_SEND_BIT: // R19
    assert property (@(posedge lclk) disable iff (!arst_n)
        link.phase == i2c_ctl_pkg::P_SEND |-> link.oe == !link.shreg[7] && !link.sda_o)
        else $error("Transmitted bit does not match the pull-down.");

    AST_RD_ANSWER: // R15
    assert property (@(posedge clk) disable iff (!arst_n)
        core.req.rd |=> core.rdata == $past(reg_rdata) && core.ack_tgl != $past(core.ack_tgl) && !core.req.rd)
        else $error("Register read not answered in one cycle.");
endmodule // i2c_ctl_port

//--- verilog/strap_decode.sv
// Decoder of the four-level address pin comparators into two strap bits.
`timescale 1ns/1ps
module strap_decode (
    input  wire logic [2:0] lvl,
    output logic      [1:0] strap
);
    // A torn thermometer code still lands on a legal level: count the comparators that are set.
    function automatic logic [1:0] ones(input logic [2:0] v);
        ones = 2'({1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]});
    endfunction

    assign strap = ones(lvl);
endmodule // strap_decode

//--- verilog/sync_2ff.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_2ff needs WIDTH of at least one.");
    end

    // The first stage feeds only the second, so a metastable value never reaches logic.
    always_comb begin
        next_st        = st;
        next_st.meta   = d;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stable;
endmodule // sync_2ff
